// >>> core/iib_ecc_gen.sv
`timescale 1ns/10ps
`default_nettype none
module iib_ecc_gen
   import iib_pkg::*;
(
   iib_ecc_if.gen ecc_port
);
   // hamming position of data bit j: skip power-of-two slots
   function automatic int unsigned pos_of(input int unsigned j);
      int unsigned p;
      int unsigned n;
      p = 2;
      n = 0;
      for (int unsigned k = 0; k < 64; k++) begin
         if (n <= j) begin
            p = p + 1;
            if ((p & (p - 1)) != 0) begin
               n = n + 1;
            end
         end
      end
      return p;
   endfunction : pos_of

   logic [5:0] ham;

   generate
      for (genvar i = 0; i < 6; i++) begin : g_ham
         always_comb begin
            ham[i] = 1'b0;
            for (int unsigned j = 0; j < WORD_BITS; j++) begin
               if (((pos_of(j) >> i) & 1) != 0) begin
                  ham[i] = ham[i] ^ ecc_port.word[j];
               end
            end
         end
      end
   endgenerate

   // overall parity turns sec into sec-ded, matching the cache array code
   assign ecc_port.check = {(^ecc_port.word) ^ (^ham), ham};
endmodule : iib_ecc_gen
`default_nettype wire

// >>> core/iib_ecc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface iib_ecc_if;
   logic [31:0] word;
   logic [6:0] check;
   modport gen (input word, output check);
   modport user (output word, input check);
endinterface : iib_ecc_if
`default_nettype wire

// >>> core/iib_inbound_path.sv
`timescale 1ns/10ps
`default_nettype none
module iib_inbound_path
   import iib_pkg::*;
#(
   parameter int unsigned RESP_CREDITS = RESP_CREDITS_DEFAULT
)(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic dma_mode_in,
   input wire logic hdr_strobe_in,
   input wire logic [127:0] inbound_data_in,
   input wire logic data_request_flag_in,
   input wire logic short_payload_flag_in,
   input wire logic bypass_select_in,
   input wire logic [3:0] inbound_parity_in,
   input wire logic [15:0] inbound_byte_enables_in,
   input wire logic l2_writes_drained_in,
   input wire logic ncu_ready_in,
   output logic ncu_valid_out,
   output logic ncu_is_interrupt_out,
   output logic [127:0] ncu_header_out,
   output logic [127:0] ncu_payload_out,
   output logic parity_error_out,
   input wire logic cmd_valid_in,
   input wire logic [1:0] cmd_kind_in,
   input wire logic cmd_nonposted_in,
   input wire logic [63:0] cmd_header_in,
   input wire logic [7:0] cmd_mask_in,
   input wire logic [511:0] cmd_data_in,
   output logic cmd_ack_out,
   output logic [31:0] cache_request_bus_out,
   output logic cache_request_strobe_out,
   output logic [6:0] write_check_bits_out,
   input wire logic cache_input_queue_release_in,
   input wire logic cache_write_buffer_release_in,
   input wire logic response_release_in
);
   generate
      if (RESP_CREDITS < 1 || RESP_CREDITS > 255) begin : g_bad_credits
         $error("RESP_CREDITS must be 1 to 255");
      end
   endgenerate

   localparam logic [CR_BITS-1:0] RESP_CR_RESET = CR_BITS'(RESP_CREDITS);

   typedef struct packed {
      logic cap_pend;
      logic cap_bypass;
      logic [127:0] cap_hdr;
      logic o_vld;
      logic o_dep;
      logic [127:0] o_hdr;
      logic [127:0] o_pay;
      logic b_vld;
      logic b_dep;
      logic [127:0] b_hdr;
      logic [127:0] b_pay;
      logic ncu_vld;
      logic ncu_int;
      logic [127:0] ncu_hdr;
      logic [127:0] ncu_pay;
      logic par_err;
      iib_l2st_type l2st;
      iib_kind_type kind;
      logic [CNT_BITS-1:0] cnt;
      logic [63:0] hdr;
      logic [511:0] data;
      logic [TOK_BITS-1:0] req_tok;
      logic [TOK_BITS-1:0] data_tok;
      logic [CR_BITS-1:0] resp_cr;
      logic ack;
      logic [31:0] bus;
      logic strobe;
      logic [6:0] ecc;
   } iib_state_type;

   iib_state_type st_r;
   iib_state_type st_nxt;
   iib_ecc_if ecc_link ();
   logic [CNT_BITS-1:0] word_idx;

   iib_ecc_gen u_ecc (
      .ecc_port(ecc_link)
   );

   //////////////////////////////////////////////////////////////////////////
   // word for the next payload cycle feeds the check-bit generator
   always_comb begin
      word_idx = (st_r.l2st == L2_HDR_LO) ? CNT_RESET : st_r.cnt;
      ecc_link.word = st_r.data[word_idx*WORD_BITS +: WORD_BITS];
   end

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic pay_par_bad;
      logic fwd_o;
      logic fwd_b;
      logic free;
      logic part_empty;
      logic can_issue;
      logic issue;
      logic [CNT_BITS-1:0] pay_len;
      pay_par_bad = 1'b0;
      st_nxt = st_r;

      // forward to the noncacheable side, ordered first when both free
      st_nxt.ncu_vld = 1'b0;
      st_nxt.par_err = 1'b0;
      fwd_o = st_r.o_vld & ~st_r.o_dep & l2_writes_drained_in & ncu_ready_in;
      fwd_b = st_r.b_vld & ~st_r.b_dep & l2_writes_drained_in & ncu_ready_in
         & ~fwd_o;
      if (fwd_o) begin
         st_nxt.o_vld = 1'b0;
         st_nxt.b_dep = 1'b0;
         st_nxt.ncu_vld = 1'b1;
         st_nxt.ncu_int = 1'b1;
         st_nxt.ncu_hdr = st_r.o_hdr;
         st_nxt.ncu_pay = st_r.o_pay;
      end else if (fwd_b) begin
         st_nxt.b_vld = 1'b0;
         st_nxt.o_dep = 1'b0;
         st_nxt.ncu_vld = 1'b1;
         st_nxt.ncu_int = 1'b0;
         st_nxt.ncu_hdr = st_r.b_hdr;
         st_nxt.ncu_pay = st_r.b_pay;
      end

      // inbound capture after forwarding, so a slot freed and refilled in one cycle keeps the new packet
      for (int g = 0; g < 4; g++) begin
         pay_par_bad = pay_par_bad
            | ((^inbound_data_in[g*32 +: 32]) != inbound_parity_in[g]);
      end
      if (hdr_strobe_in) begin
         // enables and parity are not looked at here; flags only here
         st_nxt.cap_hdr = inbound_data_in;
         st_nxt.cap_bypass = bypass_select_in;
         st_nxt.cap_pend = data_request_flag_in & short_payload_flag_in;
      end else if (st_r.cap_pend) begin
         st_nxt.cap_pend = 1'b0;
         st_nxt.par_err = pay_par_bad;
         if (st_r.cap_bypass) begin
            st_nxt.b_vld = 1'b1;
            st_nxt.b_hdr = st_r.cap_hdr;
            st_nxt.b_pay = inbound_data_in;
            st_nxt.b_dep = dma_mode_in & st_r.o_vld & ~fwd_o;
         end else begin
            st_nxt.o_vld = 1'b1;
            st_nxt.o_hdr = st_r.cap_hdr;
            st_nxt.o_pay = inbound_data_in;
            st_nxt.o_dep = st_r.b_vld & ~fwd_b;
         end
      end

      //////////////////////////////////////////////////////////////////////
      // cache request sequencer
      pay_len = (st_r.kind == KIND_WRITE_INVALIDATE_LINE) ? CNT_BITS'(LINE_PAY_WORDS)
         : (st_r.kind == KIND_READ) ? CNT_BITS'(READ_DUMMY_WORDS)
         : CNT_BITS'(PART_PAY_WORDS);
      free = (st_r.l2st == L2_IDLE) | (st_r.l2st == L2_TURN);
      part_empty = (cmd_kind_in == KIND_PARTIAL_EIGHT_BYTE_WRITE) && (cmd_mask_in == 8'h00);
      can_issue = (st_r.req_tok != 3'h0)
         && ((cmd_kind_in != KIND_WRITE_INVALIDATE_LINE) || (st_r.data_tok != 3'h0))
         && (!((cmd_kind_in == KIND_READ) || cmd_nonposted_in)
            || (st_r.resp_cr != 8'h00));
      issue = free & cmd_valid_in & ~st_r.ack & ~part_empty & can_issue;
      st_nxt.ack = free & cmd_valid_in & ~st_r.ack & (part_empty | can_issue);
      st_nxt.strobe = 1'b0;
      st_nxt.bus = 32'h0000_0000;
      st_nxt.ecc = 7'h00;

      case (st_r.l2st)
         L2_IDLE, L2_TURN: begin
            st_nxt.l2st = L2_IDLE;
            if (issue) begin
               st_nxt.l2st = L2_HDR_HI;
               st_nxt.kind = iib_kind_type'(cmd_kind_in);
               st_nxt.hdr = cmd_header_in;
               st_nxt.data = cmd_data_in;
               st_nxt.bus = cmd_header_in[63:32];
               st_nxt.strobe = 1'b1;
            end
         end
         L2_HDR_HI: begin
            st_nxt.l2st = L2_HDR_LO;
            st_nxt.bus = st_r.hdr[31:0];
         end
         L2_HDR_LO: begin
            st_nxt.l2st = L2_PAY;
            st_nxt.cnt = 5'h01;
            if (st_r.kind != KIND_READ) begin
               st_nxt.bus = ecc_link.word;
               st_nxt.ecc = ecc_link.check;
            end
         end
         L2_PAY: begin
            if (st_r.cnt == pay_len) begin
               st_nxt.l2st = L2_TURN;
            end else begin
               st_nxt.cnt = st_r.cnt + 5'h01;
               // read dummies drive zero; check bits carry nothing there
               if (st_r.kind != KIND_READ) begin
                  st_nxt.bus = ecc_link.word;
                  st_nxt.ecc = ecc_link.check;
               end
            end
         end
         default: begin
            st_nxt.l2st = L2_IDLE;
         end
      endcase

      // counters: a release in the issue cycle is not lost
      st_nxt.req_tok = st_r.req_tok - TOK_BITS'(issue)
         + TOK_BITS'(cache_input_queue_release_in);
      st_nxt.data_tok = st_r.data_tok
         - TOK_BITS'(issue && cmd_kind_in == KIND_WRITE_INVALIDATE_LINE)
         + TOK_BITS'(cache_write_buffer_release_in);
      st_nxt.resp_cr = st_r.resp_cr
         - CR_BITS'(issue && ((cmd_kind_in == KIND_READ) || cmd_nonposted_in))
         + CR_BITS'(response_release_in);

      if (srst_in) begin
         st_nxt = '0;
         st_nxt.l2st = L2_IDLE;
         st_nxt.kind = KIND_READ;
         st_nxt.req_tok = TOK_BITS'(REQ_TOKENS_RESET);
         st_nxt.data_tok = TOK_BITS'(DATA_TOKENS_RESET);
         st_nxt.resp_cr = RESP_CR_RESET;
      end
   end

   always_ff @(posedge clk_in) begin
      st_r <= st_nxt;
   end

   assign ncu_valid_out = st_r.ncu_vld;
   assign ncu_is_interrupt_out = st_r.ncu_int;
   assign ncu_header_out = st_r.ncu_hdr;
   assign ncu_payload_out = st_r.ncu_pay;
   assign parity_error_out = st_r.par_err;
   assign cmd_ack_out = st_r.ack;
   assign cache_request_bus_out = st_r.bus;
   assign cache_request_strobe_out = st_r.strobe;
   assign write_check_bits_out = st_r.ecc;

   //////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   a_strobe_once: assert property (cache_request_strobe_out |=> !cache_request_strobe_out [*4])
      else $error("request strobe held past first cycle");
   a_read_shape: assert property (cache_request_strobe_out && st_r.kind == KIND_READ
      |-> ##4 st_r.l2st == L2_TURN)
      else $error("read packet not five cycles");
   a_part_shape: assert property (cache_request_strobe_out
      && st_r.kind == KIND_PARTIAL_EIGHT_BYTE_WRITE |-> ##4 st_r.l2st == L2_TURN)
      else $error("partial write not five cycles");
   a_line_shape: assert property (cache_request_strobe_out
      && st_r.kind == KIND_WRITE_INVALIDATE_LINE |-> ##18 st_r.l2st == L2_TURN)
      else $error("line write not nineteen cycles");
   a_req_token: assert property (cache_request_strobe_out |-> $past(st_r.req_tok) != 3'h0)
      else $error("request issued without token");
   a_data_token: assert property (cache_request_strobe_out
      && st_r.kind == KIND_WRITE_INVALIDATE_LINE |-> $past(st_r.data_tok) != 3'h0)
      else $error("line write without data token");
   a_part_no_data: assert property (cache_request_strobe_out
      && st_r.kind == KIND_PARTIAL_EIGHT_BYTE_WRITE
      |-> st_r.data_tok == $past(st_r.data_tok) + TOK_BITS'($past(cache_write_buffer_release_in)))
      else $error("partial write touched data credit");
   a_part_mask: assert property (st_nxt.strobe && !srst_in
      && cmd_kind_in == KIND_PARTIAL_EIGHT_BYTE_WRITE |-> cmd_mask_in != 8'h00)
      else $error("empty partial write issued");
   a_int_order: assert property (ncu_valid_out && ncu_is_interrupt_out
      |-> $past(l2_writes_drained_in) && $past(!st_r.o_dep))
      else $error("interrupt passed pending traffic");
   a_byp_order: assert property (ncu_valid_out && !ncu_is_interrupt_out
      |-> $past(l2_writes_drained_in) && $past(!st_r.b_dep))
      else $error("completion passed pending traffic");
   a_resp_credit: assert property (cache_request_strobe_out && st_r.kind == KIND_READ
      |-> $past(st_r.resp_cr) != 8'h00)
      else $error("read issued without response credit");

   c_int_fwd: cover property (ncu_valid_out && ncu_is_interrupt_out);
   c_byp_fwd: cover property (ncu_valid_out && !ncu_is_interrupt_out);
   c_line_issue: cover property (cache_request_strobe_out
      && st_r.kind == KIND_WRITE_INVALIDATE_LINE);
   c_token_stall: cover property (cmd_valid_in && st_r.req_tok == 3'h0);
endmodule : iib_inbound_path
`default_nettype wire

// >>> core/iib_pkg.sv
package iib_pkg;
   // l2 token and packet shape
   localparam int unsigned REQ_TOKENS_RESET = 2;
   localparam int unsigned DATA_TOKENS_RESET = 4;
   localparam int unsigned RESP_CREDITS_DEFAULT = 8;
   localparam int unsigned READ_DUMMY_WORDS = 2;
   localparam int unsigned PART_PAY_WORDS = 2;
   localparam int unsigned LINE_PAY_WORDS = 16;
   localparam int unsigned WORD_BITS = 32;
   localparam int unsigned CHECK_BITS = 7;
   localparam int unsigned LINE_BITS = 512;
   localparam int unsigned HDR_BITS = 64;
   localparam int unsigned DMU_BITS = 128;
   localparam int unsigned CNT_BITS = 5;
   localparam int unsigned TOK_BITS = 3;
   localparam int unsigned CR_BITS = 8;
   localparam logic [CNT_BITS-1:0] CNT_RESET = 5'h00;

   typedef enum logic [2:0] {
      L2_IDLE = 3'h0,
      L2_HDR_HI = 3'h1,
      L2_HDR_LO = 3'h2,
      L2_PAY = 3'h3,
      L2_TURN = 3'h4
   } iib_l2st_type;

   typedef enum logic [1:0] {
      KIND_READ = 2'h0,
      KIND_PARTIAL_EIGHT_BYTE_WRITE = 2'h1,
      KIND_WRITE_INVALIDATE_LINE = 2'h2,
      KIND_SPARE = 2'h3
   } iib_kind_type;
endpackage : iib_pkg

// >>> tb/iib_inbound_path_test.sv
`timescale 1ns/10ps
`default_nettype none
module iib_inbound_path_test;
   import iib_pkg::*;
   typedef struct packed {logic is_int; logic [127:0] hdr; logic [127:0] pay;} iib_fwd_type;
   typedef struct packed {logic [1:0] kind; logic [63:0] hdr; logic [511:0] dat;} iib_cmd_type;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic dma_mode = 1'b0, hstb = 1'b0, dreq = 1'b0, spf = 1'b0, bsel = 1'b0;
   logic [127:0] idata = '0;
   logic [3:0] ipar = '0;
   logic [15:0] ibe = '0;
   logic drained = 1'b0, ready = 1'b0, slow = 1'b0;
   logic cvalid = 1'b0, cnp = 1'b0;
   logic [1:0] ckind = '0;
   logic [63:0] chdr = '0;
   logic [7:0] cmask = '0;
   logic [511:0] cdata = '0;
   logic nvalid, nint, perr, cack, strobe, iq_rel, wb_rel;
   logic [127:0] nhdr, npay;
   logic [31:0] bus;
   logic [6:0] ck;
   int n_errors = 0, tests_run = 0, n_perr = 0, n_bad = 0, tr, td, rp, wp, i;
   logic dr_d, rdy_d;
   iib_fwd_type fq[$];
   iib_fwd_type fe;
   iib_cmd_type cq[$];
   iib_cmd_type ce;
   always #2 clk_in = ~clk_in;
   iib_inbound_path #(.RESP_CREDITS(2)) iib_inbound_path_inst (.clk_in(clk_in), .srst_in(srst_in),
      .dma_mode_in(dma_mode), .hdr_strobe_in(hstb), .inbound_data_in(idata),
      .data_request_flag_in(dreq), .short_payload_flag_in(spf), .bypass_select_in(bsel),
      .inbound_parity_in(ipar), .inbound_byte_enables_in(ibe), .l2_writes_drained_in(drained),
      .ncu_ready_in(ready), .ncu_valid_out(nvalid), .ncu_is_interrupt_out(nint),
      .ncu_header_out(nhdr), .ncu_payload_out(npay), .parity_error_out(perr),
      .cmd_valid_in(cvalid), .cmd_kind_in(ckind), .cmd_nonposted_in(cnp), .cmd_header_in(chdr),
      .cmd_mask_in(cmask), .cmd_data_in(cdata), .cmd_ack_out(cack), .cache_request_bus_out(bus),
      .cache_request_strobe_out(strobe), .write_check_bits_out(ck),
      .cache_input_queue_release_in(iq_rel), .cache_write_buffer_release_in(wb_rel),
      .response_release_in(iq_rel));
   iib_l2_model iib_l2_model_inst (.clk_in(clk_in), .srst_in(srst_in), .strobe_in(strobe),
      .bus_in(bus), .slow_in(slow), .iq_release_out(iq_rel), .wb_release_out(wb_rel));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [511:0] seen, input logic [511:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask : check
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   function automatic logic [6:0] ecc_of(input logic [31:0] w);
      logic [6:0] c;
      int p;
      c = '0;
      p = 3;
      for (int b = 0; b < 32; b++) begin
         while ((p & (p - 1)) == 0) p++;
         for (int k = 0; k < 6; k++) if (p[k]) c[k] ^= w[b];
         p++;
      end
      c[6] = ^{w, c[5:0]};
      return c;
   endfunction : ecc_of
   // header cycle carries junk parity/enables, payload cycle junk flags
   task automatic send(input logic byp, input logic [127:0] p, input logic ok, input logic bad);
      logic [127:0] h;
      h = {4{32'($urandom)}};
      @(negedge clk_in);
      hstb = 1'b1; idata = h; dreq = ok; spf = 1'b1; bsel = byp;
      ipar = 4'($urandom); ibe = 16'($urandom);
      @(negedge clk_in);
      hstb = 1'b0; idata = p; ibe = 16'hFFFF;
      for (int g = 0; g < 4; g++) ipar[g] = ^p[32*g +: 32] ^ (bad && g == 0);
      dreq = 1'($urandom); spf = 1'($urandom); bsel = 1'($urandom);
      if (ok) fq.push_back({~byp, h, p});
      n_bad += bad;
   endtask : send
   // sender credit: one packet per queue, next only once forwarded; headers without the data request flag need none
   task automatic wait_fwd;
      for (int n = 0; n < 200 && fq.size() > 0; n++) begin
         @(negedge clk_in);
         ready = 1'($urandom);
      end
      check(fq.size(), 0, "forward missing");
   endtask : wait_fwd
   // hold the command until ack, then drop it in the ack cycle
   task automatic cmd(input logic [1:0] k, input logic [7:0] m);
      iib_cmd_type c;
      int n;
      c.kind = k;
      c.hdr = {k, 30'($urandom), 32'($urandom)};
      for (n = 0; n < 16; n++) c.dat[32*n +: 32] = $urandom;
      @(negedge clk_in);
      cvalid = 1'b1; ckind = k; chdr = c.hdr; cmask = m; cdata = c.dat; cnp = 1'($urandom);
      n = 0;
      while (cack !== 1'b1 && n < 400) begin
         @(negedge clk_in);
         n++;
      end
      check(n < 400, 1, "command not taken");
      cvalid = 1'b0;
      if (!(k == 2'h1 && m == 8'h00)) cq.push_back(c);
   endtask : cmd
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in) begin
      if (nvalid === 1'b1) begin
         check(dr_d & rdy_d, 1, "forward while blocked");
         if (fq.size() == 0) check(0, 1, "unexpected forward");
         else begin
            fe = fq.pop_front();
            check({nint, nhdr, npay}, fe, "forwarded packet");
         end
      end
      n_perr += (perr === 1'b1);
      dr_d = drained;
      rdy_d = ready;
   end
   // token ledger, releases count one edge late
   always @(posedge clk_in) begin
      if (srst_in) begin
         tr = REQ_TOKENS_RESET; td = DATA_TOKENS_RESET; rp = 0; wp = 0;
      end else begin
         if (strobe === 1'b1) begin
            check(tr > 0, 1, "request token");
            tr--;
            if (bus[31:30] == 2'h2) begin
               check(td > 0, 1, "data token");
               td--;
            end
         end
         tr += rp; td += wp; rp = iq_rel; wp = wb_rel;
      end
   end
   always begin
      @(posedge clk_in);
      if (strobe === 1'b1) begin
         if (cq.size() == 0) check(0, 1, "unexpected request");
         else begin
            ce = cq.pop_front();
            check(bus, ce.hdr[63:32], "header hi");
            @(posedge clk_in);
            check({strobe, bus}, {1'b0, ce.hdr[31:0]}, "header lo");
            for (int w = 0; w < (ce.kind == 2'h2 ? 16 : 2); w++) begin
               @(posedge clk_in);
               if (ce.kind == 2'h0) check({strobe, bus}, 0, "dummy");
               else check({strobe, ck, bus}, {1'b0, ecc_of(ce.dat[32*w +: 32]), ce.dat[32*w +: 32]}, "word");
            end
            @(posedge clk_in);
            check(bus, 0, "turnaround");
         end
      end
   end
   initial begin
      #40000;
      n_errors++;
      stop_test();
   end
   initial begin
      void'($urandom(49));
      repeat (4) @(posedge clk_in);
      @(negedge clk_in);
      srst_in = 1'b0;
      // dma mode: interrupt then csr read return, back to back, writes pending
      dma_mode = 1'b1; ready = 1'b1;
      send(1'b0, {4{32'($urandom)}}, 1'b1, 1'b0);
      send(1'b1, {2{64'($urandom)}}, 1'b1, 1'b0);
      repeat (12) @(negedge clk_in);
      check(fq.size(), 2, "forward before drain");
      drained = 1'b1;
      wait_fwd();
      $display("test ordered pair done");
      // plain mode: return then interrupt then a header without the data request flag
      dma_mode = 1'b0;
      for (i = 0; i < 8; i++) begin
         drained = 1'($urandom);
         send(1'b1, {4{32'($urandom)}}, 1'b1, i == 3);
         send(1'b0, {4{32'($urandom)}}, 1'b1, 1'b0);
         send(1'b0, {4{32'($urandom)}}, 1'b0, 1'b0);
         drained = 1'b1;
         wait_fwd();
      end
      check(n_perr, n_bad, "parity error count");
      $display("test mixed packets done");
      // three reads in a burst, then writes and an empty partial write
      repeat (3) cmd(2'h0, 8'hFF);
      cmd(2'h1, 8'($urandom) | 8'h01);
      cmd(2'h2, 8'hFF);
      cmd(2'h1, 8'h00);
      repeat (60) @(negedge clk_in);
      $display("test reads and writes done");
      // slow cache: line writes run out of data tokens, partial writes do not
      slow = 1'b1;
      repeat (5) begin
         cmd(2'h2, 8'hFF);
         cmd(2'h1, 8'h80);
      end
      repeat (100) @(negedge clk_in);
      check(cq.size(), 0, "requests missing");
      $display("test token limits done");
      stop_test();
   end
endmodule : iib_inbound_path_test
`default_nettype wire

// >>> tb/iib_l2_model.sv
`timescale 1ns/10ps
`default_nettype none
module iib_l2_model (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic strobe_in,
   input wire logic [31:0] bus_in,
   input wire logic slow_in,
   output logic iq_release_out,
   output logic wb_release_out
);
   int cyc;
   int last;
   int iq[$];
   int wq[$];
   // kind rides in the top header bits by bench convention; check bits on reads unused
   always @(posedge clk_in) begin
      iq_release_out <= 1'b0;
      wb_release_out <= 1'b0;
      if (srst_in) begin
         cyc = 0;
         last = -100;
         iq.delete();
         wq.delete();
      end else begin
         cyc++;
         if (strobe_in) begin
            iq.push_back(cyc);
            if (bus_in[31:30] == 2'h2) wq.push_back(cyc);
         end
         // first pulse well after the second dummy, then 17 apart
         if (iq.size() > 0 && cyc >= iq[0] + (slow_in ? 30 : 5) && cyc - last >= 17) begin
            iq_release_out <= 1'b1;
            last = cyc;
            void'(iq.pop_front());
         end
         if (wq.size() > 0 && cyc >= wq[0] + (slow_in ? 150 : 40)) begin
            wb_release_out <= 1'b1;
            void'(wq.pop_front());
         end
      end
   end
endmodule : iib_l2_model
`default_nettype wire
